// >>> pll_lock_status_and_dividers.sv
/*
 * PLL lock sticky flags, VCO output divider and serializer PLL
 * reference divider, with an AHB-Lite register slave and interrupt.
 * Assumes pll_lock_slow is asynchronous to hclk; dividers emit one
 * hclk-wide tick per divided period.
 */
`timescale 1ns/1ps

module pll_lock_status_and_dividers
  import pll_lock_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // PLL side
  input wire logic pll_lock_slow,
  output logic vco_div_tick,
  output logic ref_div_tick,
  output logic [1:0] vco_output_divider_select,
  output logic [5:0] serializer_ref_div_code,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic lock_prev;
    logic lock_seen;
    logic lock_gained;
    logic lock_lost;
    logic clr_gained;
    logic clr_lost;
    logic [1:0] vco_sel;
    logic [2:0] clk_rsvd;
    logic [5:0] ref_code;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [3:0] vco_cnt;
    logic [5:0] ref_cnt;
    logic vco_tick;
    logic ref_tick;
    logic dp_write;
    logic [2:0] dp_sel;
    logic [31:0] rdata;
    logic irq;
    logic ready;
  } state_s;

  localparam state_s STATE_RESET = '{
    vco_sel: VCO_SEL_RESET,
    clk_rsvd: CLK_RSVD_RESET,
    ref_code: REF_CODE_RESET,
    irq_mask: IRQ_MASK_RESET,
    dp_sel: SEL_NONE,
    default: '0
  };

  state_s s_q;
  state_s s_d;

  // ==========================================================
  // Address decode
  function automatic logic [2:0] decode(input logic [31:0] a);
    logic [2:0] r;
    r = SEL_NONE;
    if (a == {18'h0, IDX_CLK_DIV, 2'b00}) r = SEL_CLK_DIV;
    if (a == {18'h0, IDX_LOCK_STATUS, 2'b00}) r = SEL_LOCK;
    if (a == {18'h0, IDX_REF_DIV, 2'b00}) r = SEL_REF_DIV;
    if (a == {18'h0, IDX_IRQ_STATUS, 2'b00}) r = SEL_IRQ_STAT;
    if (a == {18'h0, IDX_IRQ_MASK, 2'b00}) r = SEL_IRQ_MASK;
    return r;
  endfunction : decode

  function automatic logic [3:0] vco_ratio(input logic [1:0] sel);
    logic [3:0] r;
    unique case (sel)
      2'b00: r = VCO_RATIO_SEL0;
      2'b01: r = VCO_RATIO_SEL1;
      2'b10: r = VCO_RATIO_SEL2;
      2'b11: r = 4'h0;
    endcase
    return r;
  endfunction : vco_ratio

  logic addr_take;
  logic wr;
  logic rise;
  logic fall;
  logic gained_clr;
  logic lost_clr;
  logic [1:0] irq_set;
  logic [2:0] asel;
  logic [3:0] vratio;

  always_comb begin
    s_d = s_q;
    addr_take = hsel && htrans[1] && hready;
    asel = decode(haddr);
    wr = s_q.dp_write;

    // ========================================================
    // Data phase writes
    if (wr && s_q.dp_sel == SEL_CLK_DIV) begin
      s_d.vco_sel = hwdata[VCO_SEL_LSB +: 2];
      s_d.clk_rsvd = hwdata[2:0];
    end
    if (wr && s_q.dp_sel == SEL_LOCK) begin
      s_d.clr_gained = hwdata[CLR_GAINED_BIT];
      s_d.clr_lost = hwdata[CLR_LOST_BIT];
    end
    if (wr && s_q.dp_sel == SEL_REF_DIV) begin
      s_d.ref_code = hwdata[5:0];
    end
    if (wr && s_q.dp_sel == SEL_IRQ_MASK) begin
      s_d.irq_mask = hwdata[1:0];
    end

    // ========================================================
    // Lock indicator synchroniser and sticky flags
    s_d.sync1 = pll_lock_slow;
    s_d.sync2 = s_q.sync1;
    s_d.lock_prev = s_q.sync2;
    rise = s_q.sync2 && !s_q.lock_prev;
    fall = !s_q.sync2 && s_q.lock_prev && s_q.lock_seen;
    if (rise) s_d.lock_seen = 1'b1;
    gained_clr = s_q.clr_gained && !s_d.clr_gained;
    lost_clr = s_q.clr_lost && !s_d.clr_lost;
    s_d.lock_gained = (s_q.lock_gained && !gained_clr) || rise;
    s_d.lock_lost = (s_q.lock_lost && !lost_clr) || fall;

    // ========================================================
    // Interrupt status: set wins over read-clear
    irq_set = 2'b00;
    irq_set[IRQ_GAINED_BIT] = rise;
    irq_set[IRQ_LOST_BIT] = fall;
    s_d.irq_stat = s_q.irq_stat | irq_set;

    // ========================================================
    // Address phase: capture select and read data
    s_d.dp_write = addr_take && hwrite;
    s_d.dp_sel = addr_take ? asel : SEL_NONE;
    s_d.ready = 1'b1;
    s_d.rdata = s_q.rdata;
    if (addr_take && !hwrite) begin
      s_d.rdata = 32'h0;
      unique case (asel)
        SEL_CLK_DIV: s_d.rdata[4:0] = {s_d.vco_sel, s_d.clk_rsvd};
        SEL_LOCK: begin
          s_d.rdata[CLR_LOST_BIT] = s_d.clr_lost;
          s_d.rdata[CLR_GAINED_BIT] = s_d.clr_gained;
          s_d.rdata[LOCK_LOST_BIT] = s_d.lock_lost;
          s_d.rdata[LOCK_GAINED_BIT] = s_d.lock_gained;
        end
        SEL_REF_DIV: s_d.rdata[5:0] = s_d.ref_code;
        SEL_IRQ_STAT: s_d.rdata[1:0] = s_d.irq_stat;
        SEL_IRQ_MASK: s_d.rdata[1:0] = s_d.irq_mask;
        default: s_d.rdata = 32'h0;
      endcase
      if (asel == SEL_IRQ_STAT) s_d.irq_stat = s_q.irq_stat & ~s_q.irq_stat | irq_set;
    end
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);

    // ========================================================
    // VCO output divider
    vratio = vco_ratio(s_q.vco_sel);
    s_d.vco_tick = 1'b0;
    if (vratio == 4'h0) begin
      s_d.vco_cnt = 4'h0;
    end else if (s_q.vco_cnt >= vratio - 4'h1) begin
      s_d.vco_cnt = 4'h0;
      s_d.vco_tick = 1'b1;
    end else begin
      s_d.vco_cnt = s_q.vco_cnt + 4'h1;
    end

    // ========================================================
    // Serializer PLL reference divider
    s_d.ref_tick = 1'b0;
    if (s_q.ref_code < REF_CODE_MIN) begin
      s_d.ref_cnt = 6'h00;
    end else if (s_q.ref_cnt >= s_q.ref_code - 6'h01) begin
      s_d.ref_cnt = 6'h00;
      s_d.ref_tick = 1'b1;
    end else begin
      s_d.ref_cnt = s_q.ref_cnt + 6'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata = s_q.rdata;
  assign hreadyout = s_q.ready;
  assign hresp = 1'b0;
  assign irq = s_q.irq;
  assign vco_div_tick = s_q.vco_tick;
  assign ref_div_tick = s_q.ref_tick;
  assign vco_output_divider_select = s_q.vco_sel;
  assign serializer_ref_div_code = s_q.ref_code;

  // ==========================================================
  // Assertions
  a_vco_div_six: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s_q.vco_tick && s_q.vco_sel == 2'b00 && s_q.vco_cnt == 4'h0)
      ##1 (s_q.vco_sel == 2'b00 && !s_q.vco_tick)[*5] |=> s_q.vco_tick)
    else $error("VCO divide by 6 period wrong");

  a_vco_div_ten: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s_q.vco_tick && s_q.vco_sel == 2'b10 && s_q.vco_cnt == 4'h0)
      ##1 (s_q.vco_sel == 2'b10 && !s_q.vco_tick)[*8]
      ##1 (s_q.vco_sel == 2'b10 && !s_q.vco_tick) |=> s_q.vco_tick)
    else $error("VCO divide by 10 period wrong");

  a_gained_sets: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s_q.sync2 && !s_q.lock_prev) |=> s_q.lock_gained)
    else $error("Lock-gained flag not set on rising lock");

  a_gained_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $fell(s_q.clr_gained) && !$past(s_q.sync2 && !s_q.lock_prev) |-> !s_q.lock_gained)
    else $error("Lock-gained flag not cleared by pulse");

  a_lost_sets: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!s_q.sync2 && s_q.lock_prev && s_q.lock_seen) |=> s_q.lock_lost)
    else $error("Lock-lost flag not set on falling lock");

  a_lost_holds: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_q.lock_lost && !(s_q.clr_lost && !s_d.clr_lost) |=> s_q.lock_lost)
    else $error("Lock-lost flag dropped without clear pulse");

  a_ref_idle: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s_q.ref_code < REF_CODE_MIN)[*2] |-> !s_q.ref_tick)
    else $error("Reference divider ticks on code 0 or 1");

  a_reset_defaults: assert property (
    @(posedge hclk)
    !hresetn |=> (!s_q.lock_gained && !s_q.lock_lost && s_q.ref_code == REF_CODE_RESET
      && s_q.vco_sel == VCO_SEL_RESET))
    else $error("Reset state wrong");

  a_vco_div_eight: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s_q.vco_tick && s_q.vco_sel == 2'b01 && s_q.vco_cnt == 4'h0)
      ##1 (s_q.vco_sel == 2'b01 && !s_q.vco_tick)[*7] |=> s_q.vco_tick)
    else $error("VCO divide by 8 period wrong");

  a_vco_tick_pulse: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_q.vco_tick |=> !s_q.vco_tick)
    else $error("VCO divider tick wider than one cycle");

  a_vco_sel_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_q.dp_write && s_q.dp_sel == SEL_CLK_DIV
      |=> s_q.vco_sel == $past(hwdata[VCO_SEL_LSB +: 2]))
    else $error("VCO select write not taken");

  a_sync_chain: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_q.sync2 == $past(s_q.sync1) && s_q.lock_prev == $past(s_q.sync2))
    else $error("Lock indicator synchroniser skipped a stage");

  a_gained_event: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s_q.sync2 && !s_q.lock_prev) |=> s_q.irq_stat[IRQ_GAINED_BIT])
    else $error("Lock-gained event missing from interrupt status");

  a_gained_only_rise: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(s_q.lock_gained) |-> $past(s_q.sync2 && !s_q.lock_prev))
    else $error("Lock-gained flag set without rising lock");

  a_gained_holds: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_q.lock_gained && !(s_q.clr_gained && !s_d.clr_gained) |=> s_q.lock_gained)
    else $error("Lock-gained flag dropped without clear pulse");

  a_clr_gained_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_q.dp_write && s_q.dp_sel == SEL_LOCK
      |=> s_q.clr_gained == $past(hwdata[CLR_GAINED_BIT]))
    else $error("Lock-gained clear bit write not taken");

  a_lost_event: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!s_q.sync2 && s_q.lock_prev && s_q.lock_seen) |=> s_q.irq_stat[IRQ_LOST_BIT])
    else $error("Lock-lost event missing from interrupt status");

  a_lost_only_fall: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(s_q.lock_lost) |-> $past(!s_q.sync2 && s_q.lock_prev && s_q.lock_seen))
    else $error("Lock-lost flag set without falling lock");

  a_lost_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $fell(s_q.clr_lost) && !$past(!s_q.sync2 && s_q.lock_prev && s_q.lock_seen)
      |-> !s_q.lock_lost)
    else $error("Lock-lost flag not cleared by pulse");

  a_clr_lost_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_q.dp_write && s_q.dp_sel == SEL_LOCK
      |=> s_q.clr_lost == $past(hwdata[CLR_LOST_BIT]))
    else $error("Lock-lost clear bit write not taken");

  a_ref_code_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_q.dp_write && s_q.dp_sel == SEL_REF_DIV
      |=> s_q.ref_code == $past(hwdata[5:0]))
    else $error("Reference divider code write not taken");

  a_ref_div_two: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s_q.ref_tick && s_q.ref_code == REF_CODE_MIN)
      ##1 (s_q.ref_code == REF_CODE_MIN && !s_q.ref_tick) |=> s_q.ref_tick)
    else $error("Reference divide by 2 period wrong");

  a_ref_cnt_below: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s_q.ref_code >= REF_CODE_MIN && s_q.ref_cnt < s_q.ref_code)
      ##1 $stable(s_q.ref_code)
      |-> s_q.ref_cnt < s_q.ref_code)
    else $error("Reference divider count passed its code");

  a_ref_tick_pulse: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_q.ref_tick |=> !s_q.ref_tick)
    else $error("Reference divider tick wider than one cycle");

endmodule : pll_lock_status_and_dividers

// >>> pll_lock_pkg.sv
/*
 * Constants for the PLL lock status and clock divider block: register
 * indices, field positions, reset values and divider ratios.
 * Assumes a 32-bit AHB-Lite bus; byte address is four times the index.
 */
package pll_lock_pkg;

  // ==========================================================
  // Register indices (byte address = index * 4)
  localparam logic [11:0] IDX_CLK_DIV = 12'hd41;
  localparam logic [11:0] IDX_LOCK_STATUS = 12'hd44;
  localparam logic [11:0] IDX_REF_DIV = 12'hd4a;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'hd50;
  localparam logic [11:0] IDX_IRQ_MASK = 12'hd51;

  // ==========================================================
  // Register selects held through the data phase
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_CLK_DIV = 3'h1;
  localparam logic [2:0] SEL_LOCK = 3'h2;
  localparam logic [2:0] SEL_REF_DIV = 3'h3;
  localparam logic [2:0] SEL_IRQ_STAT = 3'h4;
  localparam logic [2:0] SEL_IRQ_MASK = 3'h5;

  // ==========================================================
  // Field positions
  localparam int VCO_SEL_LSB = 3;
  localparam int LOCK_GAINED_BIT = 1;
  localparam int LOCK_LOST_BIT = 2;
  localparam int CLR_GAINED_BIT = 3;
  localparam int CLR_LOST_BIT = 4;
  localparam int IRQ_GAINED_BIT = 0;
  localparam int IRQ_LOST_BIT = 1;

  // ==========================================================
  // Reset values
  localparam logic [1:0] VCO_SEL_RESET = 2'h0;
  localparam logic [2:0] CLK_RSVD_RESET = 3'h7;
  localparam logic [5:0] REF_CODE_RESET = 6'h02;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

  // ==========================================================
  // Divider ratios
  localparam logic [3:0] VCO_RATIO_SEL0 = 4'h6;
  localparam logic [3:0] VCO_RATIO_SEL1 = 4'h8;
  localparam logic [3:0] VCO_RATIO_SEL2 = 4'ha;
  localparam logic [5:0] REF_CODE_MIN = 6'h02;

endpackage : pll_lock_pkg

// >>> tb.sv
/*
 * Self-checking testbench for the PLL lock status and divider block.
 * Assumes pll_lock_pkg and the design module are compiled before it.
 */
`timescale 1ns/1ps
module tb;
  import pll_lock_pkg::*;
  // ====
  // Signals
  logic hclk, hresetn, hsel, hwrite, pll_lock_slow;
  logic [31:0] haddr, hwdata, hrdata, n, k, d;
  logic [1:0] htrans, vsel;
  logic [2:0] hsize;
  logic hreadyout, hresp, vtick, rtick, irq;
  logic [5:0] rcode;
  logic [31:0] exp_q[$];
  logic [31:0] vr[3];
  logic rd_dp = 1'b0;
  int miscompares, num_checks;

  pll_lock_status_and_dividers pll_lock_status_and_dividers_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pll_lock_slow(pll_lock_slow), .vco_div_tick(vtick), .ref_div_tick(rtick),
    .vco_output_divider_select(vsel), .serializer_ref_div_code(rcode), .irq(irq)
  );

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // ====
  // Checking and bus tasks
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Read data are compared as the data phase completes
  always @(posedge hclk) begin
    if (rd_dp && hreadyout) chk(hrdata, exp_q.pop_front());
    rd_dp = hresetn && hsel && htrans[1] && !hwrite && hreadyout;
  end

  task automatic wait_rdy();
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : wait_rdy

  task automatic bus(logic wr, logic [11:0] idx, logic [31:0] v);
    @(posedge hclk);
    hsel <= 1'b1;
    hwrite <= wr;
    haddr <= {18'h0, idx, 2'b00};
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    if (wr) hwdata <= v;
    else exp_q.push_back(v);
    wait_rdy();
  endtask : bus

  task automatic settle(int c);
    repeat (c) @(posedge hclk);
    @(negedge hclk);
  endtask : settle

  // Tick spacing in cycles; 80 means no tick seen
  task automatic period(logic which, output logic [31:0] p);
    repeat (3) begin
      p = 0;
      do begin
        @(negedge hclk);
        p++;
      end while ((which ? rtick : vtick) !== 1'b1 && p < 80);
    end
  endtask : period

  task automatic done(string s);
    $display("test %s finished", s);
  endtask : done

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  initial begin
    #(4 * 40000);
    miscompares++;
    end_of_test();
  end

  // ====
  // Tests
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pll_lock_slow = 1'b0;
    vr = '{32'(VCO_RATIO_SEL0), 32'(VCO_RATIO_SEL1), 32'(VCO_RATIO_SEL2)};
    void'($urandom(35));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    settle(2);
    chk({30'h0, vsel}, 32'h0);
    chk({26'h0, rcode}, 32'h2);
    chk({31'h0, hresp}, 32'h0);
    bus(0, IDX_CLK_DIV, 32'h07);
    bus(0, IDX_REF_DIV, 32'h02);
    bus(0, IDX_LOCK_STATUS, 32'h0);
    bus(1, 12'hd45, 32'hffffffff);
    bus(0, 12'hd45, 32'h0);
    done("reset");
    for (int c = 0; c < 3; c++) begin
      d = {27'h0, 2'(c), 3'($urandom)};
      bus(1, IDX_CLK_DIV, d);
      bus(0, IDX_CLK_DIV, d);
      period(1'b0, n);
      chk(n, vr[c]);
      chk({30'h0, vsel}, 32'(c));
    end
    done("vco divider");
    for (int i = 0; i < 6; i++) begin
      k = (i < 3) ? 32'(i) : 3 + $urandom % 61;
      bus(1, IDX_REF_DIV, k);
      bus(0, IDX_REF_DIV, k);
      period(1'b1, n);
      chk(n, (k < 2) ? 32'd80 : k);
      chk({26'h0, rcode}, k);
    end
    done("ref divider");
    bus(1, IDX_IRQ_MASK, 32'h1);
    pll_lock_slow <= 1'b1;
    settle(8);
    chk({31'h0, irq}, 32'h1);
    bus(0, IDX_LOCK_STATUS, 32'h02);
    bus(0, IDX_IRQ_STATUS, 32'h1);
    pll_lock_slow <= 1'b0;
    settle(8);
    chk({31'h0, irq}, 32'h0);
    bus(0, IDX_LOCK_STATUS, 32'h06);
    bus(1, IDX_IRQ_MASK, 32'h2);
    settle(3);
    chk({31'h0, irq}, 32'h1);
    bus(0, IDX_IRQ_STATUS, 32'h2);
    settle(3);
    chk({31'h0, irq}, 32'h0);
    bus(1, IDX_LOCK_STATUS, 32'h08);
    bus(0, IDX_LOCK_STATUS, 32'h0e);
    bus(1, IDX_LOCK_STATUS, 32'h00);
    bus(0, IDX_LOCK_STATUS, 32'h04);
    bus(1, IDX_LOCK_STATUS, 32'h10);
    bus(1, IDX_LOCK_STATUS, 32'h00);
    bus(0, IDX_LOCK_STATUS, 32'h00);
    done("lock flags");
    bus(1, IDX_CLK_DIV, 32'h12);
    pll_lock_slow <= 1'b1;
    settle(8);
    @(posedge hclk);
    hresetn <= 1'b0;
    pll_lock_slow <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    settle(2);
    chk({30'h0, vsel}, 32'h0);
    bus(0, IDX_LOCK_STATUS, 32'h0);
    bus(0, IDX_CLK_DIV, 32'h07);
    done("second reset");
    end_of_test();
  end
endmodule : tb
